// >>> hdl/prlc_out_latch.sv
// one output relay latch with manual or automatic reset
`timescale 1ns/10ps
`default_nettype none
module prlc_out_latch (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cond,
	input wire logic latched,
	input wire logic man_reset,
	input wire logic fail_safe,
	output logic active,
	output logic coil
);
	import prlc_pkg::*;
	logic active_r;
	logic active_nxt;
	// set wins over a manual or automatic reset in the same cycle; rst still clears
	assign active_nxt = cond ? 1'b1 :
		(latched ? (active_r & ~man_reset) : 1'b0);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			active_r <= 1'b0;
		end else begin
			active_r <= active_nxt;
		end
	end
	assign active = active_r;
	// fail-safe coils sit energised when idle and drop on operation
	assign coil = fail_safe ? ~active_r : active_r;

	AST_LATCH_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
		active_r && latched && !cond && !man_reset |=> active_r)
		else $error("latched output dropped without manual reset");
	AST_SET_ON_COND: assert property (@(posedge sys_clk) disable iff (rst)
		cond |=> active_r)
		else $error("output not set by its condition");
	AST_AUTO_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		!latched && !cond |=> !active_r)
		else $error("unlatched output did not clear");
	AST_MAN_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		man_reset && !cond |=> !active_r)
		else $error("manual reset did not clear output");
endmodule : prlc_out_latch
`default_nettype wire

// >>> hdl/prlc_top.sv
// setpoint handling and output latching of a motor protection relay
`timescale 1ns/10ps
`default_nettype none
module prlc_top #(
	parameter bit EXTENDED = 1'b1,
	// step length in clock cycles; only a simulation would shorten it
	parameter int STEP_CYCLES = prlc_pkg::PRLC_STEP_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	// ------------------------------------------------------------
	// settings
	// ------------------------------------------------------------
	input wire logic cfg_load,
	input wire logic cfg_ssw_defeat,
	input wire logic [7:0] cfg_ssw_delay,
	input wire logic [1:0] cfg_ao_src,
	input wire logic cfg_single_shot_en,
	input wire logic cfg_start_inhibit_en,
	input wire logic cfg_special_reset_en,
	input wire logic cfg_phase_rev_en,
	input wire logic [3:0] cfg_latch_code,
	input wire logic [3:0] cfg_fail_safe_code,
	// ------------------------------------------------------------
	// pins and measurements
	// ------------------------------------------------------------
	input wire logic ssw_pin,
	input wire logic man_reset_pin,
	input wire logic motor_starting,
	input wire logic phase_rev_det,
	input wire logic trip_cond,
	input wire logic alarm_cond,
	input wire logic imm_ol_alarm,
	input wire logic aux1_cond,
	input wire logic aux2_cond,
	input wire logic [7:0] thermal_used,
	input wire logic [7:0] load_pct,
	input wire logic [7:0] stator_hot_c,
	input wire logic [7:0] ct_sec_pct,
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	output logic ssw_delay_visible,
	output logic single_shot_en,
	output logic start_inhibit_en,
	output logic special_reset_en,
	output logic [7:0] ao_level,
	output logic trip_active,
	output logic alarm_active,
	output logic aux1_active,
	output logic aux2_active,
	output logic [3:0] relay_coil
);
	import prlc_pkg::*;

	// ------------------------------------------------------------
	// stored setpoints
	// ------------------------------------------------------------
	logic ssw_defeat_r;
	logic [7:0] ssw_delay_r;
	logic [1:0] ao_src_r;
	logic ss_en_r;
	logic si_en_r;
	logic sr_en_r;
	logic pr_en_r;
	logic [3:0] latch_code_r;
	logic [3:0] fs_code_r;
	wire delay_ok = (cfg_ssw_delay >= PRLC_SSW_DLY_MIN) && (cfg_ssw_delay <= PRLC_SSW_DLY_MAX);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ssw_defeat_r <= PRLC_SSW_DEFEAT_RST;
			ssw_delay_r <= PRLC_SSW_DLY_RST;
			ao_src_r <= PRLC_AO_RST;
			ss_en_r <= PRLC_ENA_RST;
			si_en_r <= PRLC_ENA_RST;
			sr_en_r <= PRLC_ENA_RST;
			pr_en_r <= PRLC_ENA_RST;
			latch_code_r <= PRLC_LATCH_RST;
			fs_code_r <= PRLC_FAILSAFE_RST;
		end else if (cfg_load) begin
			ssw_defeat_r <= cfg_ssw_defeat;
			// out-of-range delay keeps the old value; it cannot be reached while hidden
			if (delay_ok && !cfg_ssw_defeat) begin
				ssw_delay_r <= cfg_ssw_delay;
			end
			ao_src_r <= cfg_ao_src;
			ss_en_r <= cfg_single_shot_en;
			si_en_r <= cfg_start_inhibit_en;
			sr_en_r <= cfg_special_reset_en;
			pr_en_r <= cfg_phase_rev_en;
			latch_code_r <= cfg_latch_code;
			fs_code_r <= cfg_fail_safe_code;
		end
	end
	assign ssw_delay_visible = ~ssw_defeat_r;
	assign single_shot_en = ss_en_r;
	assign start_inhibit_en = si_en_r;
	assign special_reset_en = sr_en_r;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] ssw_sync_r;
	logic [1:0] mr_sync_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ssw_sync_r <= 2'h0;
			mr_sync_r <= 2'h0;
		end else begin
			ssw_sync_r <= {ssw_sync_r[0], ssw_pin};
			mr_sync_r <= {mr_sync_r[0], man_reset_pin};
		end
	end
	// only the second stage is read, the first may be metastable
	wire ssw_closed = ssw_sync_r[1];
	wire man_reset = mr_sync_r[1];

	// ------------------------------------------------------------
	// speed switch timer
	// ------------------------------------------------------------
	// trip when the switch stays open during a start for the set delay
	localparam logic [24:0] STEP_CYC = 25'(STEP_CYCLES);
	logic [24:0] sub_r;
	logic [7:0] steps_r;
	logic ssw_trip_r;
	wire ssw_run = ~ssw_defeat_r & motor_starting & ~ssw_closed;
	wire sub_wrap = (sub_r == STEP_CYC - 25'h1);
	wire ssw_expire = ssw_run && sub_wrap && (steps_r + 8'h1 >= ssw_delay_r);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sub_r <= 25'h0;
			steps_r <= 8'h0;
			ssw_trip_r <= 1'b0;
		end else if (!ssw_run) begin
			sub_r <= 25'h0;
			steps_r <= 8'h0;
			ssw_trip_r <= 1'b0;
		end else begin
			sub_r <= sub_wrap ? 25'h0 : sub_r + 25'h1;
			// counting stops at expiry so the step count cannot wrap
			if (sub_wrap && !ssw_trip_r) begin
				steps_r <= steps_r + 8'h1;
			end
			if (ssw_expire) begin
				ssw_trip_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// analog output selection
	// ------------------------------------------------------------
	wire [7:0] stator_clip = (stator_hot_c > PRLC_STATOR_FS_C) ? PRLC_STATOR_FS_C : stator_hot_c;
	// stator span 0..200 C scaled onto 0..255
	wire [15:0] stator_prod = 16'(stator_clip) * 16'h00ff;
	wire [7:0] stator_scaled = 8'(stator_prod / 16'(PRLC_STATOR_FS_C));
	logic [7:0] ao_sel;
	always_comb begin
		case (prlc_ao_e'(ao_src_r))
			PRLC_AO_THERMAL: ao_sel = thermal_used;
			PRLC_AO_LOAD: ao_sel = load_pct;
			PRLC_AO_STATOR: ao_sel = stator_scaled;
			PRLC_AO_CT_SEC: ao_sel = ct_sec_pct;
			default: ao_sel = stator_scaled;
		endcase
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ao_level <= 8'h0;
		end else begin
			ao_level <= ao_sel;
		end
	end

	// ------------------------------------------------------------
	// latch decode
	// ------------------------------------------------------------
	function automatic logic [1:0] latch_decode(input logic [3:0] code, input logic ext);
		logic [1:0] res;
		res = 2'h0;
		if (ext) begin
			res[0] = (code >= 4'h2) && (code <= 4'h7) && (code != 4'h4) && (code != 4'h5);
			res[1] = (code >= 4'h4) && (code <= 4'h7);
		end else begin
			res[0] = (code == 4'h2) || (code == 4'h3) || (code == 4'h6) || (code == 4'h7);
		end
		return res;
	endfunction : latch_decode

	wire [1:0] lat = latch_decode(latch_code_r, EXTENDED);
	wire pr_trip = pr_en_r & phase_rev_det;
	wire [PRLC_NUM_OUT-1:0] conds = {aux2_cond & EXTENDED, aux1_cond & EXTENDED,
		alarm_cond, trip_cond | ssw_trip_r | pr_trip};
	// trip and second auxiliary always latched
	wire [PRLC_NUM_OUT-1:0] latched_v = {1'b1, lat[1], lat[0], 1'b1};
	wire [PRLC_NUM_OUT-1:0] act_v;
	// fail-safe code bits: trip, alarm, aux1; second auxiliary always fail-safe
	wire [PRLC_NUM_OUT-1:0] fs_v = {1'b1, fs_code_r[2], fs_code_r[1], fs_code_r[0]};
	logic [PRLC_NUM_OUT-1:0] coil_v;

	genvar gi;
	generate
		for (gi = 0; gi < PRLC_NUM_OUT; gi++) begin : g_out
			prlc_out_latch u_latch (
				.sys_clk(sys_clk),
				.rst(rst),
				.cond(conds[gi]),
				.latched(latched_v[gi]),
				.man_reset(man_reset),
				.fail_safe(fs_v[gi]),
				.active(act_v[gi]),
				.coil(coil_v[gi])
			);
		end
	endgenerate

	// immediate overload alarm bypasses the latch and follows its condition
	assign trip_active = act_v[0];
	assign alarm_active = act_v[1] | imm_ol_alarm;
	assign aux1_active = act_v[2];
	assign aux2_active = act_v[3];
	// alarm coil is rebuilt here so the overload bypass reaches the relay too
	wire alarm_coil = fs_v[1] ? ~alarm_active : alarm_active;
	assign relay_coil = {coil_v[3:2], alarm_coil, coil_v[0]};

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_SSW_DEFEATED: assert property (@(posedge sys_clk) disable iff (rst)
		ssw_defeat_r |=> !ssw_trip_r)
		else $error("speed switch trip while defeated");
	AST_DELAY_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
		ssw_delay_r >= PRLC_SSW_DLY_MIN && ssw_delay_r <= PRLC_SSW_DLY_MAX)
		else $error("speed switch delay out of range");
	AST_DELAY_FROZEN: assert property (@(posedge sys_clk) disable iff (rst)
		ssw_defeat_r && cfg_load |=> $stable(ssw_delay_r) || !ssw_defeat_r)
		else $error("hidden delay changed");
	AST_TRIP_LATCH: assert property (@(posedge sys_clk) disable iff (rst)
		trip_active && !man_reset |=> trip_active)
		else $error("trip cleared without manual reset");
	AST_IMM_OL: assert property (@(posedge sys_clk) disable iff (rst)
		imm_ol_alarm |-> alarm_active)
		else $error("immediate overload alarm not shown");
	AST_CODE1: assert property (@(posedge sys_clk) disable iff (rst)
		latch_code_r == 4'h1 |-> lat == 2'h0)
		else $error("code one latched an output");
	AST_PHASE_REV: assert property (@(posedge sys_clk) disable iff (rst)
		!pr_en_r && !trip_cond && !ssw_trip_r && phase_rev_det |-> !conds[0])
		else $error("phase reversal tripped while disabled");
	AST_AO_CT: assert property (@(posedge sys_clk) disable iff (rst)
		ao_src_r == 2'h3 |=> ao_level == $past(ct_sec_pct))
		else $error("ct source not routed");
	AST_AO_STATOR: assert property (@(posedge sys_clk) disable iff (rst)
		ao_src_r == 2'h2 && stator_hot_c >= PRLC_STATOR_FS_C |=> ao_level == 8'hff)
		else $error("stator full scale not reached");
	AST_SSW_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		!ssw_run |=> !ssw_trip_r)
		else $error("speed switch trip outlived its run");
	AST_PR_TRIP: assert property (@(posedge sys_clk) disable iff (rst)
		pr_en_r && phase_rev_det |=> trip_active)
		else $error("enabled phase reversal did not trip");
	AST_ALARM_AUTO: assert property (@(posedge sys_clk) disable iff (rst)
		!lat[0] && !alarm_cond |=> !act_v[1])
		else $error("unlatched alarm held");
	AST_AUX2_LATCH: assert property (@(posedge sys_clk) disable iff (rst)
		aux2_active && !man_reset |=> aux2_active)
		else $error("second auxiliary cleared without manual reset");
	AST_AUX_BASIC: assert property (@(posedge sys_clk) disable iff (rst)
		!EXTENDED |-> !aux1_active && !aux2_active)
		else $error("auxiliary output active on basic model");
	AST_CODES_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg_load |=> $stable(latch_code_r) && $stable(fs_code_r))
		else $error("code changed without load");
	AST_ENABLES_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg_load |=> $stable({ss_en_r, si_en_r, sr_en_r}))
		else $error("enable changed without load");

	// ------------------------------------------------------------
	// cover points
	// ------------------------------------------------------------
	COV_SSW_TRIP: cover property (@(posedge sys_clk) ssw_trip_r);
	COV_REV_TRIP: cover property (@(posedge sys_clk) pr_trip ##1 trip_active);
	COV_AUX_HELD: cover property (@(posedge sys_clk) aux1_active && !aux1_cond ##1 aux1_active);
	COV_MAN_RESET: cover property (@(posedge sys_clk) trip_active ##1 !trip_active);
	COV_ALARM_AUTO: cover property (@(posedge sys_clk) alarm_active && !lat[0] ##1 !alarm_active);
endmodule : prlc_top
`default_nettype wire

// >>> shared/prlc_pkg.sv
// package for the protection output latch and configuration block
`default_nettype none
package prlc_pkg;
	// speed switch delay in half-second steps
	localparam int PRLC_SSW_STEP_MS = 500;
	localparam logic [7:0] PRLC_SSW_DLY_MIN = 8'h01;
	localparam logic [7:0] PRLC_SSW_DLY_MAX = 8'hc8;
	localparam logic [7:0] PRLC_SSW_DLY_RST = 8'h04;
	localparam int PRLC_CLK_HZ = 50000000;
	localparam int PRLC_STEP_CYC = PRLC_CLK_HZ / 1000 * PRLC_SSW_STEP_MS;
	// analog output sources
	typedef enum logic [1:0] {
		PRLC_AO_THERMAL,
		PRLC_AO_LOAD,
		PRLC_AO_STATOR,
		PRLC_AO_CT_SEC
	} prlc_ao_e;
	localparam logic [1:0] PRLC_AO_RST = 2'h2;
	localparam logic [7:0] PRLC_STATOR_FS_C = 8'hc8;
	// latch and fail-safe codes
	localparam logic [3:0] PRLC_LATCH_RST = 4'h1;
	localparam logic [3:0] PRLC_FAILSAFE_RST = 4'h1;
	// factory defaults of the yes/no settings
	localparam logic PRLC_SSW_DEFEAT_RST = 1'b1;
	localparam logic PRLC_ENA_RST = 1'b0;
	localparam int PRLC_NUM_OUT = 4;
endpackage : prlc_pkg
`default_nettype wire

// >>> testbench/prlc_motor_model.sv
// motor control circuit model wired to the relay contacts
`timescale 1ns/10ps
`default_nettype none
module prlc_motor_model (
	input wire logic [3:0] relay_coil,
	output logic contactor_closed,
	output logic alarm_lamp
);
	// ----------------------------------------
	// contacts
	// ----------------------------------------
	// trip contact is a permissive: the contactor holds only while the trip coil is energised
	assign contactor_closed = relay_coil[0];
	assign alarm_lamp = relay_coil[1];
endmodule : prlc_motor_model
`default_nettype wire

// >>> testbench/tb.sv
// self-checking testbench of the protection output latch block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import prlc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_load = 1'b0, cfg_ssw_defeat = 1'b1, ssw_pin = 1'b1, man_reset_pin = 1'b0;
	logic [7:0] cfg_ssw_delay = 8'h04;
	logic [1:0] cfg_ao_src = 2'h2;
	logic [3:0] en = 4'h0, cfg_latch_code = 4'h1, cfg_fail_safe_code = 4'h1;
	logic motor_starting = 1'b0, phase_rev_det = 1'b0, trip_cond = 1'b0, alarm_cond = 1'b0;
	logic imm_ol_alarm = 1'b0, aux1_cond = 1'b0, aux2_cond = 1'b0;
	logic [7:0] thermal_used = 8'h3c, load_pct = 8'h5a, stator_hot_c = 8'hd2, ct_sec_pct = 8'h77;
	logic ssw_delay_visible, single_shot_en, start_inhibit_en, special_reset_en;
	logic trip_active, alarm_active, aux1_active, aux2_active, contactor_closed;
	logic alarm_lamp, b_trip_active, b_alarm_active, b_aux1_active, b_aux2_active;
	// short step keeps the speed switch run brief
	localparam int SIM_STEP = 10;
	logic [7:0] ao_level;
	logic [3:0] relay_coil;
	int miscompares = 0;
	int n_compared = 0;
	always #10 sys_clk = ~sys_clk;
	prlc_top #(.EXTENDED(1'b1), .STEP_CYCLES(SIM_STEP)) uut (.sys_clk(sys_clk), .rst(rst),
		.cfg_load(cfg_load),
		.cfg_ssw_defeat(cfg_ssw_defeat), .cfg_ssw_delay(cfg_ssw_delay), .cfg_ao_src(cfg_ao_src),
		.cfg_single_shot_en(en[0]), .cfg_start_inhibit_en(en[1]), .cfg_special_reset_en(en[2]),
		.cfg_phase_rev_en(en[3]), .cfg_latch_code(cfg_latch_code),
		.cfg_fail_safe_code(cfg_fail_safe_code), .ssw_pin(ssw_pin), .man_reset_pin(man_reset_pin),
		.motor_starting(motor_starting), .phase_rev_det(phase_rev_det), .trip_cond(trip_cond),
		.alarm_cond(alarm_cond), .imm_ol_alarm(imm_ol_alarm), .aux1_cond(aux1_cond),
		.aux2_cond(aux2_cond), .thermal_used(thermal_used), .load_pct(load_pct),
		.stator_hot_c(stator_hot_c), .ct_sec_pct(ct_sec_pct), .ssw_delay_visible(ssw_delay_visible),
		.single_shot_en(single_shot_en), .start_inhibit_en(start_inhibit_en),
		.special_reset_en(special_reset_en), .ao_level(ao_level), .trip_active(trip_active),
		.alarm_active(alarm_active), .aux1_active(aux1_active), .aux2_active(aux2_active),
		.relay_coil(relay_coil));
	prlc_motor_model motor (.relay_coil(relay_coil), .contactor_closed(contactor_closed),
		.alarm_lamp(alarm_lamp));
	// basic model shares every input; only its latch outputs are judged
	prlc_top #(.EXTENDED(1'b0), .STEP_CYCLES(SIM_STEP)) uut_basic (.sys_clk(sys_clk),
		.rst(rst), .cfg_load(cfg_load), .cfg_ssw_defeat(cfg_ssw_defeat),
		.cfg_ssw_delay(cfg_ssw_delay), .cfg_ao_src(cfg_ao_src), .cfg_single_shot_en(en[0]),
		.cfg_start_inhibit_en(en[1]), .cfg_special_reset_en(en[2]), .cfg_phase_rev_en(en[3]),
		.cfg_latch_code(cfg_latch_code), .cfg_fail_safe_code(cfg_fail_safe_code),
		.ssw_pin(ssw_pin), .man_reset_pin(man_reset_pin), .motor_starting(motor_starting),
		.phase_rev_det(phase_rev_det), .trip_cond(trip_cond), .alarm_cond(alarm_cond),
		.imm_ol_alarm(imm_ol_alarm), .aux1_cond(aux1_cond), .aux2_cond(aux2_cond),
		.thermal_used(thermal_used), .load_pct(load_pct), .stator_hot_c(stator_hot_c),
		.ct_sec_pct(ct_sec_pct), .ssw_delay_visible(), .single_shot_en(), .start_inhibit_en(),
		.special_reset_en(), .ao_level(), .trip_active(b_trip_active),
		.alarm_active(b_alarm_active), .aux1_active(b_aux1_active),
		.aux2_active(b_aux2_active), .relay_coil());
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic cfg(input logic dft, input logic [1:0] src, input logic [3:0] e,
			input logic [3:0] lc, input logic [3:0] fs);
		@(posedge sys_clk);
		cfg_load <= 1'b1;
		cfg_ssw_defeat <= dft;
		cfg_ao_src <= src;
		en <= e;
		cfg_latch_code <= lc;
		cfg_fail_safe_code <= fs;
		@(posedge sys_clk);
		cfg_load <= 1'b0;
		cyc(2);
	endtask : cfg
	// sync flops plus latch make the reset land three edges after the pin
	task automatic man_reset();
		@(posedge sys_clk);
		man_reset_pin <= 1'b1;
		cyc(4);
		man_reset_pin <= 1'b0;
		cyc(4);
	endtask : man_reset
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults();
		chk("ssw visible", 8'h0, ssw_delay_visible);
		chk("enables", 8'h0, {single_shot_en, start_inhibit_en, special_reset_en});
		chk("ao stator", 8'hff, ao_level);
		chk("coil idle", 8'h9, relay_coil);
		motor_starting <= 1'b1;
		ssw_pin <= 1'b0;
		cyc(60);
		chk("no ssw trip", 8'h0, trip_active);
		motor_starting <= 1'b0;
		ssw_pin <= 1'b1;
		cfg(1'b0, 2'h2, 4'h7, 4'h1, 4'h1);
		chk("ssw visible", 8'h1, ssw_delay_visible);
		chk("enables", 8'h7, {special_reset_en, start_inhibit_en, single_shot_en});
		$display("test defaults done");
	endtask : t_defaults
	task automatic t_speed_switch();
		// out-of-range delay is refused, so the earlier value of 4 steps still applies
		cfg_ssw_delay <= 8'hc9;
		cfg(1'b0, 2'h2, 4'h0, 4'h1, 4'h1);
		motor_starting <= 1'b1;
		ssw_pin <= 1'b0;
		cyc(SIM_STEP * PRLC_SSW_DLY_RST);
		chk("ssw early", 8'h0, trip_active);
		cyc(8);
		chk("ssw trip", 8'h1, trip_active);
		chk("contactor open", 8'h0, contactor_closed);
		motor_starting <= 1'b0;
		ssw_pin <= 1'b1;
		cyc(4);
		chk("ssw trip kept", 8'h1, trip_active);
		man_reset();
		chk("ssw trip cleared", 8'h0, trip_active);
		$display("test speed switch done");
	endtask : t_speed_switch
	task automatic t_analog();
		logic [7:0] exp [4];
		stator_hot_c <= 8'h64;
		exp = '{8'h3c, 8'h5a, 8'h7f, 8'h77};
		for (int s = 0; s < 4; s++) begin
			cfg(1'b1, s[1:0], 4'h0, 4'h1, 4'h1);
			chk("ao level", exp[s], ao_level);
		end
		$display("test analog done");
	endtask : t_analog
	task automatic t_latch_codes();
		for (int c = 1; c < 8; c++) begin
			cfg(1'b1, 2'h2, 4'h0, c[3:0], 4'h1);
			{alarm_cond, aux1_cond, aux2_cond, trip_cond} <= 4'hf;
			cyc(3);
			{alarm_cond, aux1_cond, aux2_cond, trip_cond} <= 4'h0;
			cyc(3);
			chk("alarm latch", {7'h0, c[1]}, alarm_active);
			chk("aux1 latch", {7'h0, c[2]}, aux1_active);
			chk("aux2 latch", 8'h1, aux2_active);
			chk("trip latch", 8'h1, trip_active);
			chk("basic alarm latch", {7'h0, c[1]}, b_alarm_active);
			chk("basic trip latch", 8'h1, b_trip_active);
			chk("basic aux masked", 8'h0, {b_aux1_active, b_aux2_active});
			man_reset();
			chk("all clear", 8'h0, {trip_active, alarm_active, aux1_active, aux2_active});
			chk("basic clear", 8'h0, {b_trip_active, b_alarm_active});
		end
		$display("test latch codes done");
	endtask : t_latch_codes
	task automatic t_trip_and_alarm();
		cfg(1'b1, 2'h2, 4'h0, 4'h7, 4'h5);
		imm_ol_alarm <= 1'b1;
		cyc(2);
		chk("imm ol on", 8'h1, alarm_active);
		chk("coil alarm fs", 8'hf, relay_coil);
		chk("alarm lamp", 8'h1, alarm_lamp);
		imm_ol_alarm <= 1'b0;
		cyc(2);
		chk("imm ol off", 8'h0, alarm_active);
		phase_rev_det <= 1'b1;
		cyc(5);
		chk("rev disabled", 8'h0, trip_active);
		cfg(1'b1, 2'h2, 4'h8, 4'h7, 4'h5);
		cyc(2);
		chk("rev trip", 8'h1, trip_active);
		chk("contactor open", 8'h0, contactor_closed);
		man_reset();
		chk("held by cond", 8'h1, trip_active);
		phase_rev_det <= 1'b0;
		cyc(4);
		chk("trip kept", 8'h1, trip_active);
		man_reset();
		chk("trip cleared", 8'h0, trip_active);
		$display("test trip and alarm done");
	endtask : t_trip_and_alarm
	task automatic end_of_test();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test
	initial begin
		cyc(16);
		rst <= 1'b0;
		cyc(4);
		t_defaults();
		t_speed_switch();
		t_analog();
		t_latch_codes();
		t_trip_and_alarm();
		end_of_test();
	end
	initial begin
		#200us;
		miscompares++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
